/* File: common/pcs_pkg.sv */
package pcs_pkg;
    localparam int DW = 8;
    // register indices on the plain port
    localparam logic [0:0] ADDR_CTRL = 1'h0;
    localparam logic [0:0] ADDR_TEST = 1'h1;
    // control fields
    localparam int CB_HPOL = 0;
    localparam int CB_VPOL = 1;
    localparam int CB_SPLIT = 2;
    localparam int CB_NIB = 3;
    localparam int CB_PED = 4;
    localparam int CB_SYNC = 5;
    localparam int CB_SEL = 7;
    localparam logic [7:0] CTRL_RESET = 8'h03;
    // test register fields
    localparam int TB_RES = 3;
    localparam int TB_ASEL_LO = 4;
    localparam logic [3:0] ASEL_R_B = 4'hA;
    localparam logic [3:0] ASEL_R_REF = 4'h9;
    localparam logic [3:0] ASEL_G_B = 4'h6;
    localparam logic [3:0] ASEL_G_REF = 4'h5;
    // channel selector codes
    localparam logic [2:0] CH_PAL_R = 3'h0;
    localparam logic [2:0] CH_PAL_G = 3'h1;
    localparam logic [2:0] CH_PAL_B = 3'h2;
    localparam logic [2:0] CH_ID = 3'h3;
    localparam logic [2:0] CH_ACC_R = 3'h4;
    localparam logic [2:0] CH_ACC_G = 3'h5;
    localparam logic [2:0] CH_ACC_B = 3'h6;
    localparam logic [2:0] CH_ANALOG = 3'h7;
    // arbitrary identification value
    localparam logic [7:0] ID_DEFAULT = 8'h5A;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pcs_rgb_t;

    typedef struct packed {
        logic blank_n;
        logic hsync_n;
        logic vsync_n;
    } pcs_vid_t;
endpackage

/* File: src/pcs_palette_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1: select output low at reset and in pass-through, else control bit 7.
// RULE2: bits 0/1 pick hsync/vsync output polarity, 1 active high, default 1.
// RULE3: polarity acts only in normal modes; pass-through passes syncs as-is.
// RULE4: split transfer when bits 3:2 are 01; nibble mode when 10.
// RULE5: bit 4 selects pedestal, 0 none, 1 7.5 IRE.
// RULE6: bit 5 enables sync on the green current output.
// RULE7: bit 6 is reserved, default 0, no effect.
// RULE8: bit 7 only drives the select output, default 0.
// RULE9: test write stores selector from bits 2:0; read returns channel data.
// RULE10: selector codes map palette rgb, id, accumulations rgb, analog test.
// RULE11: palette channel reads return feed value, then step r-g-b-r.
// RULE12: id read returns static id then steps to red.
// RULE13: per palette word, add one-bit count of selected byte to accumulator.
// RULE14: temporary accumulator is 8 bits and wraps past 255.
// RULE15: accumulation runs at half the pixel clock.
// RULE16: vsync falling edge latches accumulator to result, then clears it.
// RULE17: selector changes before next frame to a different color byte.
// RULE18: analog test bits 7:4 are rw selects, bit 3 read-only result.
// RULE19: codes 1010, 1001, 0110, 0101 pick comparator pair; 1 means first greater.
// RULE20: comparator result captured on falling edge of blank strobe.
// RULE21: host writes 0000 into select bits outside analog test.
// RULE22: host holds pixel data steady during palette channel reads.
// RULE23: syncs and blank sampled per mode: video or pass-through clock.
// RULE24: accumulation selector rotates 100, 101, 110, 100 each frame.
// RULE25: accumulation read returns latched result, not running sum.
module pcs_palette_ctrl
    import pcs_pkg::*;
#(
    parameter logic [7:0] ID_CODE = ID_DEFAULT
)(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic passthru_i,
    input wire logic video_timing_clock_fall_i,
    input wire logic ptclk_rise_i,
    input wire pcs_vid_t vid_i,
    input wire pcs_rgb_t pal_i,
    input wire logic pal_valid_i,
    input wire logic cmp_rb_i,
    input wire logic cmp_rref_i,
    input wire logic cmp_gb_i,
    input wire logic cmp_gref_i,
    output logic horiz_sync_output_o,
    output logic vert_sync_output_o,
    output logic external_select_output_o,
    output logic split_transfer_enable_o,
    output logic nibble_mode_enable_o,
    output logic pedestal_enable_o,
    output logic sync_on_green_enable_o,
    output logic [3:0] analog_sel_o
);
    logic [7:0] general_control;
    logic [2:0] sel;
    logic [3:0] asel;
    logic cmp_res;
    pcs_vid_t vid_q;
    logic vsync_d;
    logic blank_d;
    logic half;
    logic [7:0] acc_tmp;
    pcs_rgb_t acc_res;
    logic next_cmp;
    logic [7:0] next_rdata;
    logic vs_fall;
    logic wr_ctrl;
    logic wr_test;
    logic rd_test;
    logic rd_ctrl;
    logic [2:0] next_sel;

    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // normal modes: active-low inputs through a true/complement gate
    function automatic logic sync_out(input logic in_n, input logic pol,
        input logic pt);
        logic o;
        if (pt)
        begin
            o = in_n;
        end
        else
        begin
            o = in_n ^ pol;
        end
        return o;
    endfunction

    // byte under watch for the accumulation channel in s
    function automatic logic [7:0] acc_byte(input logic [2:0] s,
        input pcs_rgb_t p);
        logic [7:0] b;
        b = p.blue;
        if (s == CH_ACC_R)
        begin
            b = p.red;
        end
        else if (s == CH_ACC_G)
        begin
            b = p.green;
        end
        return b;
    endfunction

    assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
    assign wr_test = wr_i && (addr_i == ADDR_TEST);
    assign rd_test = rd_i && (addr_i == ADDR_TEST);
    assign rd_ctrl = rd_i && (addr_i == ADDR_CTRL);

    // bit 6 is stored and read back but drives no control output
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            general_control <= CTRL_RESET;
        else if (wr_ctrl)
            general_control <= wdata_i; // [RULE2] [RULE7] [RULE8]
    end

    assign split_transfer_enable_o = general_control[CB_SPLIT]
        && !general_control[CB_NIB]; // [RULE4]
    assign nibble_mode_enable_o = general_control[CB_NIB]
        && !general_control[CB_SPLIT]; // [RULE4]
    assign pedestal_enable_o = general_control[CB_PED]; // [RULE5]
    assign sync_on_green_enable_o = general_control[CB_SYNC]; // [RULE6]
    assign analog_sel_o = asel; // [RULE19]

    // sample inputs on the mode's own clock edge
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            vid_q <= '1;
        else if (passthru_i ? ptclk_rise_i : video_timing_clock_fall_i)
            vid_q <= vid_i; // [RULE23]
    end

    // registered, so entering pass-through shows one stale cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            horiz_sync_output_o <= 1'b0;
        else
            horiz_sync_output_o <= sync_out(vid_q.hsync_n,
                general_control[CB_HPOL], passthru_i); // [RULE2] [RULE3]
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            vert_sync_output_o <= 1'b0;
        else
            vert_sync_output_o <= sync_out(vid_q.vsync_n,
                general_control[CB_VPOL], passthru_i); // [RULE2] [RULE3]
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            external_select_output_o <= 1'b0;
        else if (passthru_i)
            external_select_output_o <= 1'b0; // [RULE1]
        else
            external_select_output_o <= general_control[CB_SEL]; // [RULE1]
    end

    // only the vsync pin counts, composite syncs never reach here
    assign vs_fall = vsync_d && !vid_q.vsync_n; // [RULE16]

    // idle high after reset, so no false edge follows release
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            vsync_d <= 1'b1;
        else
            vsync_d <= vid_q.vsync_n;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            blank_d <= 1'b1;
        else
            blank_d <= vid_q.blank_n;
    end

    // free-running phase, not tied to frame start
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            half <= 1'b0;
        else
            half <= ~half; // [RULE15]
    end

    // half rate: circuit speed limit, alternate words are skipped
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            acc_tmp <= 8'h00;
        else if (vs_fall)
            acc_tmp <= 8'h00; // [RULE16]
        else if (half && pal_valid_i && sel[2] && sel != CH_ANALOG) // [RULE15]
        begin
            acc_tmp <= acc_tmp
                + {4'h0, ones8(acc_byte(sel, pal_i))}; // [RULE13] [RULE14]
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            acc_res <= '0;
        else if (vs_fall)
        begin
            unique case (sel)
                CH_ACC_R: acc_res.red <= acc_tmp; // [RULE16]
                CH_ACC_G: acc_res.green <= acc_tmp; // [RULE16]
                CH_ACC_B: acc_res.blue <= acc_tmp; // [RULE16]
                default: acc_res <= acc_res;
            endcase
        end
    end

    // write wins over a read or frame step in the same cycle
    always_comb
    begin
        next_sel = sel;
        if (wr_test)
        begin
            next_sel = wdata_i[2:0]; // [RULE9]
        end
        else if (rd_test)
        begin
            unique case (sel)
                CH_PAL_R: next_sel = CH_PAL_G; // [RULE11]
                CH_PAL_G: next_sel = CH_PAL_B; // [RULE11]
                CH_PAL_B: next_sel = CH_PAL_R; // [RULE11]
                CH_ID: next_sel = CH_PAL_R; // [RULE12]
                default: next_sel = sel;
            endcase
        end
        else if (vs_fall)
        begin
            unique case (sel)
                CH_ACC_R: next_sel = CH_ACC_G; // [RULE17] [RULE24]
                CH_ACC_G: next_sel = CH_ACC_B; // [RULE17] [RULE24]
                CH_ACC_B: next_sel = CH_ACC_R; // [RULE17] [RULE24]
                default: next_sel = sel;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            sel <= CH_PAL_R;
        else
            sel <= next_sel;
    end

    // host keeps 0000 outside analog test; stored as written
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            asel <= 4'h0;
        else if (wr_test)
            asel <= wdata_i[7:TB_ASEL_LO]; // [RULE18] [RULE21]
    end

    always_comb
    begin
        unique case (asel)
            ASEL_R_B: next_cmp = cmp_rb_i; // [RULE19]
            ASEL_R_REF: next_cmp = cmp_rref_i; // [RULE19]
            ASEL_G_B: next_cmp = cmp_gb_i; // [RULE19]
            ASEL_G_REF: next_cmp = cmp_gref_i; // [RULE19]
            default: next_cmp = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cmp_res <= 1'b0;
        else if (blank_d && !vid_q.blank_n)
            cmp_res <= next_cmp; // [RULE20]
    end

    always_comb
    begin
        unique case (sel)
            CH_PAL_R: next_rdata = pal_i.red; // [RULE11] [RULE22]
            CH_PAL_G: next_rdata = pal_i.green; // [RULE11]
            CH_PAL_B: next_rdata = pal_i.blue; // [RULE11]
            CH_ID: next_rdata = ID_CODE; // [RULE12]
            CH_ACC_R: next_rdata = acc_res.red; // [RULE25]
            CH_ACC_G: next_rdata = acc_res.green; // [RULE25]
            CH_ACC_B: next_rdata = acc_res.blue; // [RULE25]
            default: next_rdata = {asel, cmp_res, sel}; // [RULE18]
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_o <= 8'h00;
        else if (rd_ctrl)
            // whole register, reserved bit 6 included
            rdata_o <= general_control;
        else if (rd_test)
            rdata_o <= next_rdata; // [RULE9] [RULE10]
        else
            rdata_o <= 8'h00;
    end
endmodule // pcs_palette_ctrl

/* File: testbench/pcs_palette_ctrl_checker.sv */
`timescale 1ns/1ps
module pcs_palette_ctrl_checker
    import pcs_pkg::*;
#(
    parameter logic [7:0] ID_CODE = ID_DEFAULT
)(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic passthru_i,
    input wire logic ptclk_rise_i,
    input wire pcs_vid_t vid_i,
    input wire logic horiz_sync_output_o,
    input wire logic vert_sync_output_o,
    input wire logic external_select_output_o,
    input wire logic split_transfer_enable_o,
    input wire logic nibble_mode_enable_o,
    input wire logic pedestal_enable_o,
    input wire logic sync_on_green_enable_o,
    input wire logic [3:0] analog_sel_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    wire logic cw = wr_i && addr_i == ADDR_CTRL;
    wire logic tw = wr_i && addr_i == ADDR_TEST;
    property p_sel_pt;
        passthru_i |=> !external_select_output_o;
    endproperty
    a_sel_pt: assert property (p_sel_pt) else $error("sel high");
    property p_sel_bit;
        cw && !passthru_i ##1 !passthru_i && !wr_i
            |=> external_select_output_o == $past(wdata_i[CB_SEL], 2);
    endproperty
    a_sel_bit: assert property (p_sel_bit) else $error("sel bit");
    property p_modes;
        cw |=> split_transfer_enable_o == ($past(wdata_i[3:2]) == 2'h1)
            && nibble_mode_enable_o == ($past(wdata_i[3:2]) == 2'h2);
    endproperty
    a_modes: assert property (p_modes) else $error("modes");
    property p_video;
        cw |=> pedestal_enable_o == $past(wdata_i[CB_PED])
            && sync_on_green_enable_o == $past(wdata_i[CB_SYNC]);
    endproperty
    a_video: assert property (p_video) else $error("video");
    property p_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_id;
        tw && wdata_i[2:0] == CH_ID ##1 !(wr_i || rd_i)
            ##1 rd_i && addr_i == ADDR_TEST && !wr_i |=> rdata_o == ID_CODE;
    endproperty
    a_id: assert property (p_id) else $error("id read");
    property p_asel;
        tw && wdata_i[2:0] == CH_ANALOG |=> analog_sel_o == $past(wdata_i[7:4]);
    endproperty
    a_asel: assert property (p_asel) else $error("asel");
    property p_pt_sync;
        passthru_i && ptclk_rise_i ##1 passthru_i
            |=> {horiz_sync_output_o, vert_sync_output_o}
            == $past({vid_i.hsync_n, vid_i.vsync_n}, 2);
    endproperty
    a_pt_sync: assert property (p_pt_sync) else $error("pt sync");
endmodule // pcs_palette_ctrl_checker
bind pcs_palette_ctrl pcs_palette_ctrl_checker #(.ID_CODE(ID_CODE))
    pcs_palette_ctrl_checker_i (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .passthru_i, .ptclk_rise_i, .vid_i, .horiz_sync_output_o,
    .vert_sync_output_o, .external_select_output_o, .split_transfer_enable_o,
    .nibble_mode_enable_o, .pedestal_enable_o, .sync_on_green_enable_o,
    .analog_sel_o);

/* File: testbench/pcs_host_model.sv */
`timescale 1ns/1ps
module pcs_host_model
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        {addr_o, wdata_o, wr_o, rd_o} = 11'h000;
    end
    // callers keep test-register bits 7:4 zero outside analog
    task automatic wr(input logic a, input logic [7:0] v);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic a, output logic [7:0] v);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        // data stand only this cycle; take them once settled
        @(negedge clk_i);
        v = rdata_i;
        @(posedge clk_i);
    endtask
endmodule // pcs_host_model

/* File: testbench/pcs_palette_ctrl_tb.sv */
`timescale 1ns/1ps
module pcs_palette_ctrl_tb
    import pcs_pkg::*;
;
    logic clk_i, nrst_i, addr_i, wr_i, rd_i, passthru_i, video_timing_clock_fall_i;
    logic ptclk_rise_i, pal_valid_i, cmp_rb_i, cmp_rref_i, cmp_gb_i;
    logic cmp_gref_i, horiz_sync_output_o, vert_sync_output_o;
    logic external_select_output_o, split_transfer_enable_o;
    logic nibble_mode_enable_o, pedestal_enable_o, sync_on_green_enable_o;
    logic [7:0] wdata_i, rdata_o, d, w;
    logic [3:0] analog_sel_o, r;
    logic [3:0] codes [4] = '{ASEL_R_B, ASEL_R_REF, ASEL_G_B, ASEL_G_REF};
    logic [23:0] pw;
    pcs_vid_t vid_i;
    pcs_rgb_t pal_i;
    int mismatches, comparisons, n, s;
    int acc [3];
    pcs_palette_ctrl pcs_palette_ctrl_i (.clk_i, .nrst_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .passthru_i, .video_timing_clock_fall_i, .ptclk_rise_i,
        .vid_i, .pal_i, .pal_valid_i, .cmp_rb_i, .cmp_rref_i, .cmp_gb_i,
        .cmp_gref_i, .horiz_sync_output_o, .vert_sync_output_o,
        .external_select_output_o, .split_transfer_enable_o,
        .nibble_mode_enable_o, .pedestal_enable_o, .sync_on_green_enable_o,
        .analog_sel_o);
    pcs_host_model pcs_host_model_i (.clk_i, .rdata_i(rdata_o),
        .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rt(input logic a, input logic [7:0] exp);
        logic [7:0] v;
        pcs_host_model_i.rd(a, v);
        chk(v, exp);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        cyc(20000);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        {nrst_i, passthru_i, pal_valid_i, cmp_rb_i, cmp_rref_i} = 5'h00;
        {cmp_gb_i, cmp_gref_i, video_timing_clock_fall_i, ptclk_rise_i} = 4'h3;
        vid_i = 3'h7;
        pal_i = 24'h000000;
        void'($urandom(57));
        cyc(10);
        nrst_i <= 1'b1;
        cyc(1);
        rt(ADDR_CTRL, CTRL_RESET);
        for (int m = 0; m < 8; m++)
        begin
            d = 8'($urandom);
            d[3:2] = 2'(m);
            passthru_i <= m[2];
            pcs_host_model_i.wr(ADDR_CTRL, d);
            cyc(1);
            chk({3'h0, external_select_output_o, split_transfer_enable_o,
                nibble_mode_enable_o, pedestal_enable_o, sync_on_green_enable_o},
                {3'h0, d[7] & !m[2], d[3:2] == 2'h1, d[3:2] == 2'h2, d[4],
                d[5]});
            rt(ADDR_CTRL, d);
        end
        $display("control test done");
        for (int m = 0; m < 16; m++)
        begin
            passthru_i <= 1'b0;
            pcs_host_model_i.wr(ADDR_CTRL, 8'(m & 3));
            vid_i.hsync_n <= m[2];
            vid_i.vsync_n <= m[3];
            cyc(3);
            chk({6'h0, horiz_sync_output_o, vert_sync_output_o},
                {6'h0, m[2] ^ m[0], m[3] ^ m[1]});
            passthru_i <= 1'b1;
            cyc(3);
            chk({6'h0, horiz_sync_output_o, vert_sync_output_o},
                {6'h0, m[2], m[3]});
        end
        passthru_i <= 1'b0;
        video_timing_clock_fall_i <= 1'b0;
        vid_i.hsync_n <= 1'b0;
        cyc(3);
        chk({7'h0, horiz_sync_output_o}, 8'h00);
        video_timing_clock_fall_i <= 1'b1;
        cyc(3);
        chk({7'h0, horiz_sync_output_o}, 8'h01);
        vid_i <= 3'h7;
        $display("sync test done");
        pw = 24'($urandom);
        pal_i <= pw; // steady over the reads
        pcs_host_model_i.wr(ADDR_TEST, {5'h0, CH_ID});
        rt(ADDR_TEST, ID_DEFAULT);
        for (int k = 0; k < 5; k++)
            rt(ADDR_TEST, pw[23 - 8 * (k % 3) -: 8]);
        $display("palette test done");
        pcs_host_model_i.wr(ADDR_TEST, {5'h0, CH_ACC_R});
        for (int c = 0; c < 3; c++)
        begin
            pw = 24'($urandom);
            if (c == 0)
                pw[23:16] = 8'hFF;
            n = $urandom_range(70, 40);
            w = pw[23 - 8 * c -: 8];
            s = 0;
            for (int i = 0; i < 8; i++)
                s += w[i];
            acc[c] = (n * s) % 256;
            pal_i <= pw;
            pal_valid_i <= 1'b1;
            cyc(2 * n); // even span, half rate gives n adds
            pal_valid_i <= 1'b0;
            cyc(4);
            vid_i.vsync_n <= 1'b0;
            cyc(4);
            vid_i.vsync_n <= 1'b1;
            cyc(4);
        end
        rt(ADDR_TEST, 8'(acc[0]));
        for (int c = 0; c < 3; c++)
        begin
            pcs_host_model_i.wr(ADDR_TEST, 8'(4 + c));
            rt(ADDR_TEST, 8'(acc[c]));
        end
        $display("accumulation test done");
        for (int k = 0; k < 4; k++)
        begin
            r = 4'($urandom);
            {cmp_rb_i, cmp_rref_i, cmp_gb_i, cmp_gref_i} <= r;
            pcs_host_model_i.wr(ADDR_TEST, {codes[k], 1'b1, CH_ANALOG});
            vid_i.blank_n <= 1'b0;
            cyc(4);
            vid_i.blank_n <= 1'b1;
            rt(ADDR_TEST, {codes[k], r[3 - k], CH_ANALOG});
        end
        pcs_host_model_i.wr(ADDR_TEST, 8'h00);
        $display("analog test done");
        end_of_test();
    end
endmodule // pcs_palette_ctrl_tb
